/* hdl/smc_pkg.sv */
package smc_pkg;

    // ==========================================================
    // Register map and field layout
    localparam logic [7:0] smc_reg_power_control = 8'h35;
    localparam logic [7:0] smc_reg_wake_status = 8'h36;
    localparam logic [7:0] smc_reg_clock_status = 8'h37;
    localparam logic [7:0] smc_power_control_reset = 8'h00;
    localparam int smc_sleep_enable_pos = 5;
    localparam int smc_mode_lsb = 2;
    localparam int smc_mode_msb = 4;
    localparam logic [31:0] smc_unmapped_read = 32'hdeadbeef;

    // ==========================================================
    // Timing
    localparam int smc_clk_mhz = 50;
    localparam int smc_standby_wake_cycles = 6;
    localparam int smc_irq_halt_cycles = 4;
    localparam logic [15:0] smc_default_startup_cycles = 16'h0006;

    // ==========================================================
    // Modes
    typedef enum logic [2:0] {
        smc_mode_idle = 3'b000,
        smc_mode_noise = 3'b001,
        smc_mode_powerdown = 3'b010,
        smc_mode_powersave = 3'b011,
        smc_mode_rsvd4 = 3'b100,
        smc_mode_rsvd5 = 3'b101,
        smc_mode_standby = 3'b110,
        smc_mode_ext_standby = 3'b111
    } smc_mode_type;

    // Clock gate enables, one per domain; 1 means the clock runs.
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic osc;
    } smc_clocks_type;

    localparam smc_clocks_type smc_all_running = 6'h3f;

    // Wake sources, each a level from the interrupt or reset logic.
    typedef struct packed {
        logic any_irq;
        logic adc_done;
        logic ext_reset;
        logic wdt_reset;
        logic bod_reset;
        logic two_wire_match;
        logic timer0_irq;
        logic spm_ready;
        logic [3:0] ext_irq_lines_high;
        logic [3:0] ext_irq_lines_low;
    } smc_wake_type;

    // Timer0 context that qualifies its wake in the asynchronous modes.
    typedef struct packed {
        logic timer0_async_clock_select;
        logic timer0_irq_enabled;
        logic global_irq_enable;
    } smc_timer_ctx_type;

endpackage

/* hdl/smc_wake_decode.sv */
// Decides which wake events count in a given mode and what clocks that mode stops.
module smc_wake_decode
    import smc_pkg::*;
(
    input wire smc_mode_type mode,
    input wire smc_wake_type wake,
    input wire smc_timer_ctx_type tctx,
    output logic wake_hit,
    output logic reset_hit,
    output smc_clocks_type clocks
);

    logic ext_lines;
    logic timer_async_ok;

    always_comb begin
        ext_lines = (|wake.ext_irq_lines_low) | (|wake.ext_irq_lines_high);
        reset_hit = wake.ext_reset | wake.wdt_reset | wake.bod_reset;
        timer_async_ok = tctx.timer0_async_clock_select & tctx.timer0_irq_enabled
            & tctx.global_irq_enable & wake.timer0_irq;
        clocks = smc_all_running;
        wake_hit = 1'b0;
        case (mode)
            smc_mode_idle: begin
                clocks.cpu = 1'b0; // [R5]
                clocks.flash = 1'b0;
                wake_hit = wake.any_irq | ext_lines | reset_hit; // [R6]
            end
            smc_mode_noise: begin
                clocks.cpu = 1'b0; // [R8]
                clocks.flash = 1'b0;
                clocks.io = 1'b0;
                wake_hit = wake.adc_done | reset_hit | wake.two_wire_match
                    | wake.timer0_irq | wake.spm_ready | ext_lines; // [R9]
            end
            smc_mode_powerdown, smc_mode_standby: begin
                clocks = '0; // [R10]
                clocks.osc = (mode == smc_mode_standby); // [R17]
                wake_hit = reset_hit | wake.two_wire_match | ext_lines; // [R11]
            end
            smc_mode_powersave, smc_mode_ext_standby: begin
                clocks = '0; // [R15]
                clocks.asy = tctx.timer0_async_clock_select;
                clocks.osc = (mode == smc_mode_ext_standby); // [R18]
                wake_hit = reset_hit | wake.two_wire_match | ext_lines
                    | timer_async_ok; // [R14]
            end
            default: begin
                clocks.cpu = 1'b0;
                clocks.flash = 1'b0;
                wake_hit = wake.any_irq | ext_lines | reset_hit;
            end
        endcase
    end

endmodule // smc_wake_decode

/* hdl/smc_sleep_ctrl.sv */
// What this block does
// [R1] Sleep instruction puts the device to sleep only while sleep enable bit is one.
// [R2] Software sets sleep enable just before sleeping and clears it after waking.
// [R3] Mode field bits 4..2 selects idle, noise, power-down, power-save, standby modes.
// [R4] Standby modes need an external crystal or resonator as clock source.
// [R5] Idle stops only core and flash clocks.
// [R6] Idle wakes on any enabled interrupt, external or internal.
// [R7] Entering idle or noise reduction starts a conversion when converter enabled.
// [R8] Noise reduction stops I/O, core and flash clocks.
// [R9] Noise reduction wakes on conversion done, resets, match, timer0, ready, lines.
// [R10] Power-down stops oscillator and all generated clocks.
// [R11] Power-down wakes on resets, address match or external interrupt lines.
// [R12] A level wake source holds its level long enough to be seen.
// [R13] Power-down wake waits a fuse-selected start-up period.
// [R14] Power-save is power-down plus async timer0 wake when enables set.
// [R15] Power-save stops all clocks except the asynchronous timer clock.
// [R16] Software uses power-down rather than power-save without async timer clock.
// [R17] Standby is power-down with oscillator running, waking within six cycles.
// [R18] Extended standby is power-save with oscillator running, six-cycle wake.
// [R19] Power control register at 0x35, all bits read/write, resets to zero.
// [R20] Interrupt wake halts four extra cycles; reset during sleep restarts from reset vector.
// [R21] Register file and data memory are kept across sleep.
// [R22] Reserved mode codes sleep as idle.
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter logic [15:0] startup_cycles = smc_default_startup_cycles
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleep_instr,
    input wire logic clock_source_external_xtal,
    input wire logic adc_enabled,
    input wire smc_wake_type wake_in,
    input wire smc_timer_ctx_type timer_ctx,
    output smc_clocks_type clock_enables,
    output logic core_halted,
    output logic adc_start_conversion,
    output logic wake_via_reset,
    output logic wake_done
);

    // ==========================================================
    // Declarations
    typedef enum logic [2:0] {
        smc_st_run = 3'b000,
        smc_st_sleep = 3'b001,
        smc_st_startup = 3'b010,
        smc_st_halt = 3'b011
    } smc_state_type;

    smc_state_type state;
    smc_state_type next_state;
    logic [7:0] power_control_reg;
    smc_mode_type active_mode;
    smc_mode_type next_mode;
    logic [15:0] delay_count;
    logic [15:0] next_delay;
    logic wake_hit;
    logic reset_hit;
    logic reset_wake;
    logic next_reset_wake;
    logic accept_sleep;
    smc_clocks_type sleep_clocks;
    smc_wake_type wake_s1;
    smc_wake_type wake_s2;
    logic bus_ack;
    logic [7:0] wake_sticky;

    function automatic smc_mode_type smc_resolve_mode(input logic [2:0] code, input logic xtal);
        smc_mode_type m;
        m = smc_mode_type'(code);
        if (m == smc_mode_rsvd4 || m == smc_mode_rsvd5) begin
            m = smc_mode_idle; // [R22]
        end
        if ((m == smc_mode_standby || m == smc_mode_ext_standby) && !xtal) begin
            m = smc_mode_idle; // [R4]
        end
        return m;
    endfunction

    function automatic logic [15:0] smc_wake_delay(input smc_mode_type m,
                                                    input logic [15:0] startup);
        logic [15:0] d;
        d = 16'h0001;
        case (m)
            smc_mode_powerdown, smc_mode_powersave: d = startup; // [R13]
            smc_mode_standby, smc_mode_ext_standby: d = 16'(smc_standby_wake_cycles); // [R17] [R18]
            default: d = 16'h0001;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Wake input synchroniser
    // Wake sources come from other clocks and pins, so each passes two stages.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_s1 <= '0;
        end else begin
            wake_s1 <= wake_in;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_s2 <= '0;
        end else begin
            wake_s2 <= wake_s1;
        end
    end

    smc_wake_decode u_decode (
        .mode(active_mode),
        .wake(wake_s2),
        .tctx(timer_ctx),
        .wake_hit(wake_hit),
        .reset_hit(reset_hit),
        .clocks(sleep_clocks)
    );

    // ==========================================================
    // Sleep sequencer
    assign accept_sleep = sleep_instr & power_control_reg[smc_sleep_enable_pos]; // [R1]

    always_comb begin
        next_state = state;
        next_mode = active_mode;
        next_delay = delay_count;
        next_reset_wake = reset_wake;
        case (state)
            smc_st_run: begin
                if (accept_sleep) begin
                    next_state = smc_st_sleep;
                    next_mode = smc_resolve_mode(
                        power_control_reg[smc_mode_msb:smc_mode_lsb],
                        clock_source_external_xtal); // [R3]
                    next_reset_wake = 1'b0;
                end
            end
            smc_st_sleep: begin
                if (wake_hit) begin
                    next_state = smc_st_startup;
                    next_delay = smc_wake_delay(active_mode, startup_cycles);
                    next_reset_wake = reset_hit;
                end
            end
            smc_st_startup: begin
                if (delay_count <= 16'h0001) begin
                    // A reset wake skips the interrupt halt: the core restarts at the reset vector.
                    next_state = reset_wake ? smc_st_run : smc_st_halt; // [R20]
                    next_delay = 16'(smc_irq_halt_cycles);
                end else begin
                    next_delay = delay_count - 16'h0001;
                end
            end
            smc_st_halt: begin
                if (delay_count <= 16'h0001) begin
                    next_state = smc_st_run;
                end else begin
                    next_delay = delay_count - 16'h0001;
                end
            end
            default: next_state = smc_st_run;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= smc_st_run;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active_mode <= smc_mode_idle;
        end else begin
            active_mode <= next_mode;
        end
    end

    // The delay counter serves both the start-up wait and the interrupt halt.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            delay_count <= 16'h0000;
        end else begin
            delay_count <= next_delay;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reset_wake <= 1'b0;
        end else begin
            reset_wake <= next_reset_wake;
        end
    end

    // ==========================================================
    // Outputs
    // Clocks come back already in start-up so the oscillator can settle before the core runs.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clock_enables <= smc_all_running;
        end else begin
            clock_enables <= (next_state == smc_st_sleep) ? next_mode_clocks() : smc_all_running;
            if (next_state == smc_st_halt) begin
                clock_enables.cpu <= 1'b0;
                clock_enables.flash <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_halted <= 1'b0;
        end else begin
            // Only clock gating happens here; register file and memory are never touched.
            core_halted <= (next_state != smc_st_run); // [R21]
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            adc_start_conversion <= 1'b0;
        end else begin
            adc_start_conversion <= (state == smc_st_run) && accept_sleep && adc_enabled
                && (next_mode == smc_mode_idle || next_mode == smc_mode_noise); // [R7]
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_via_reset <= 1'b0;
        end else begin
            wake_via_reset <= (state != smc_st_run) && (next_state == smc_st_run)
                && reset_wake; // [R20]
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_done <= 1'b0;
        end else begin
            wake_done <= (state != smc_st_run) && (next_state == smc_st_run);
        end
    end

    // The decoder follows the registered mode, so on entry the gating is worked out here too.
    function automatic smc_clocks_type next_mode_clocks();
        smc_clocks_type c;
        c = sleep_clocks;
        if (state == smc_st_run) begin
            c = smc_all_running;
            c.cpu = 1'b0;
            c.flash = 1'b0;
            if (next_mode != smc_mode_idle) begin
                c.io = 1'b0;
            end
            if (next_mode != smc_mode_idle && next_mode != smc_mode_noise) begin
                c.adc = 1'b0;
                c.asy = timer_ctx.timer0_async_clock_select
                    && (next_mode == smc_mode_powersave || next_mode == smc_mode_ext_standby);
                c.osc = (next_mode == smc_mode_standby || next_mode == smc_mode_ext_standby);
            end
        end
        return c;
    endfunction

    // ==========================================================
    // Register bus
    // One wait cycle on every access keeps read data registered.
    // Writes land at the edge that completes the transfer, where waitrequest is seen low.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~bus_ack);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            power_control_reg <= smc_power_control_reset; // [R19]
        end else if (avs_write && bus_ack && avs_address == smc_reg_power_control) begin
            power_control_reg <= avs_writedata[7:0]; // [R19]
        end
    end

    // Wake history, set on every return to run; set wins over a software clear in the same cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_sticky <= 8'h00;
        end else begin
            wake_sticky[0] <= (wake_sticky[0] & ~(avs_write && bus_ack
                && avs_address == smc_reg_wake_status && avs_writedata[0]))
                | ((state != smc_st_run) && (next_state == smc_st_run));
            wake_sticky[7:1] <= 7'h00;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            case (avs_address)
                smc_reg_power_control: avs_readdata <= {24'h000000, power_control_reg};
                smc_reg_wake_status: avs_readdata <= {24'h000000, wake_sticky};
                // Sequencer state sits in bits 10..8, the live clock gates in bits 5..0.
                smc_reg_clock_status: avs_readdata <= {16'h0000, 5'h00, state,
                    2'h0, clock_enables};
                default: avs_readdata <= smc_unmapped_read;
            endcase
        end
    end

endmodule // smc_sleep_ctrl

/* verif/smc_sleep_ctrl_asserts.sv */
module smc_sleep_ctrl_asserts
    import smc_pkg::*;
#(
    parameter logic [15:0] startup_cycles = smc_default_startup_cycles
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sleep_instr,
    input wire logic clock_source_external_xtal,
    input wire logic adc_enabled,
    input wire smc_wake_type wake_in,
    input wire smc_timer_ctx_type timer_ctx,
    input wire smc_clocks_type clock_enables,
    input wire logic core_halted,
    input wire logic adc_start_conversion,
    input wire logic wake_via_reset,
    input wire logic wake_done
);
    // ==========================================================
    // Shadow of the control byte, taken at the edge a bus write completes.
    logic [7:0] shadow;
    logic go;
    logic [2:0] md;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shadow <= 8'h00;
        end else if (avs_write && !avs_waitrequest && avs_address == smc_reg_power_control) begin
            shadow <= avs_writedata[7:0];
        end
    end

    assign go = sleep_instr && !core_halted && shadow[smc_sleep_enable_pos];
    assign md = shadow[smc_mode_msb:smc_mode_lsb];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Properties
    sleep_off_a: assert property (
        sleep_instr && !core_halted && !shadow[5] |=> !core_halted && clock_enables == 6'h3f
    ) else $error("sleep taken while disabled");
    idle_clk_a: assert property (
        go && (md == 3'b000 || md[2:1] == 2'b10) |=> core_halted && clock_enables == 6'h0f
    ) else $error("idle clocks wrong");
    noise_clk_a: assert property (
        go && md == 3'b001 |=> core_halted && clock_enables == 6'h07
    ) else $error("noise clocks wrong");
    pdown_clk_a: assert property (
        go && md == 3'b010 |=> core_halted && clock_enables == 6'h00
    ) else $error("power-down clocks wrong");
    psave_clk_a: assert property (
        go && md == 3'b011 |=> core_halted && (clock_enables & 6'h3d) == 6'h00
    ) else $error("power-save clocks wrong");
    standby_clk_a: assert property (
        go && md == 3'b110 && clock_source_external_xtal |=> clock_enables == 6'h01
    ) else $error("standby clocks wrong");
    nox_idle_a: assert property (
        go && md[2:1] == 2'b11 && !clock_source_external_xtal |=> clock_enables == 6'h0f
    ) else $error("standby without crystal");
    adc_start_a: assert property (
        go && md[2:1] == 2'b00 && adc_enabled |=> adc_start_conversion
    ) else $error("no conversion start");
    asleep_hold_a: assert property (
        (core_halted && wake_in == '0) [*3] |=> core_halted
    ) else $error("woke with no source");
    reg_read_a: assert property (
        avs_read && !avs_waitrequest && avs_address == smc_reg_power_control
            |-> avs_readdata[7:0] == shadow
    ) else $error("control read mismatch");
endmodule // smc_sleep_ctrl_asserts

bind smc_sleep_ctrl smc_sleep_ctrl_asserts #(.startup_cycles(startup_cycles))
    u_smc_sleep_ctrl_asserts (.*);

/* verif/smc_core_model.sv */
module smc_core_model
    import smc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sleep_go,
    input wire smc_wake_type wake_go,
    input wire logic wake_done,
    output logic sleep_instr,
    output smc_wake_type wake_in
);
    // ==========================================================
    // Core side: one-cycle sleep pulse, wake levels held until seen.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sleep_instr <= 1'b0;
        end else begin
            sleep_instr <= sleep_go;
        end
    end

    // Dropping a level before the controller answers could lose the wake.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_in <= '0;
        end else if (wake_done) begin
            wake_in <= '0;
        end else if (wake_go != '0) begin
            wake_in <= wake_go;
        end
    end
endmodule // smc_core_model

/* verif/smc_sleep_ctrl_tb.sv */
module smc_sleep_ctrl_tb import smc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int su = 8;
    localparam logic [5:0] clk_tab [8] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h0f, 6'h0f, 6'h01, 6'h03};
    logic mclk, nrst, avs_read, avs_write, avs_waitrequest, sleep_instr, sleep_go;
    logic xtal, adc_enabled, core_halted, adc_start_conversion, wake_via_reset, wake_done;
    logic [7:0] avs_address;
    logic [7:0] st;
    logic [31:0] avs_writedata, avs_readdata;
    smc_wake_type wake_in, wake_go;
    smc_timer_ctx_type timer_ctx;
    smc_clocks_type clock_enables;
    int miscompares, cmp_count, cycles;

    assign st = {adc_start_conversion, core_halted, clock_enables};

    smc_sleep_ctrl #(.startup_cycles(16'(su))) u_smc_sleep_ctrl (
        .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .sleep_instr, .clock_source_external_xtal(xtal), .adc_enabled,
        .wake_in, .timer_ctx(timer_ctx), .clock_enables, .core_halted, .adc_start_conversion,
        .wake_via_reset, .wake_done
    );
    smc_core_model u_smc_core_model (
        .mclk, .nrst, .sleep_go, .wake_go, .wake_done, .sleep_instr, .wake_in
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic enter(input logic [2:0] m, input logic se);
        logic [31:0] rd;
        bus(1'b1, smc_reg_power_control, {2'b00, se, m, 2'b00}, rd);
        @(posedge mclk) sleep_go <= 1'b1;
        @(posedge mclk) sleep_go <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic wake(input smc_wake_type w, output int n, output logic r);
        n = 99;
        r = 1'b0;
        @(posedge mclk) wake_go <= w;
        @(posedge mclk) wake_go <= '0;
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            r = r | wake_via_reset;
            if (wake_done === 1'b1) begin
                n = i;
                break;
            end
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] rd;
        bus(1'b0, smc_reg_power_control, 8'h00, rd);
        check(rd, 32'h0, "reset value");
        bus(1'b1, smc_reg_power_control, 8'hc3, rd);
        bus(1'b0, smc_reg_power_control, 8'h00, rd);
        check(rd, 32'hc3, "readback c3");
        bus(1'b1, smc_reg_power_control, 8'h1c, rd);
        bus(1'b0, smc_reg_power_control, 8'h00, rd);
        check(rd, 32'h1c, "readback 1c");
        bus(1'b0, 8'h40, 8'h00, rd);
        check(rd, smc_unmapped_read, "unmapped read");
        enter(3'b010, 1'b0);
        check(32'(st), 32'h3f, "sleep while disabled");
    endtask

    task automatic t_modes;
        logic [31:0] rd;
        smc_wake_type w;
        int n;
        int lo;
        logic r;
        for (int m = 0; m < 8; m++) begin
            enter(m[2:0], 1'b1);
            check(32'(st), 32'({m[2:1] != 2'b01 && m[2:1] != 2'b11, 1'b1, clk_tab[m]}),
                  "sleep state");
            w = '0;
            if (m == 0 || m[2:1] == 2'b10) begin
                w.any_irq = 1'b1;
            end else begin
                w.ext_irq_lines_low = 4'h1;
            end
            wake(w, n, r);
            lo = (m == 2 || m == 3) ? su : (m[2:1] == 2'b11 ? smc_standby_wake_cycles : 0);
            check(32'(n >= lo && n <= lo + 10), 32'h1, "wake latency");
            @(negedge mclk);
            check(32'(st), 32'h3f, "running after wake");
            bus(1'b1, smc_reg_power_control, 8'h00, rd);
        end
    endtask

    task automatic t_timer;
        logic [31:0] rd;
        smc_wake_type w;
        int n;
        logic r;
        w = '0;
        w.timer0_irq = 1'b1;
        timer_ctx <= 3'b110;
        enter(3'b011, 1'b1);
        wake(w, n, r);
        check(32'(n), 32'd99, "timer wake without global enable");
        @(posedge mclk) timer_ctx <= 3'b111;
        wake(w, n, r);
        check(32'(n < 40), 32'h1, "timer wake in power-save");
        enter(3'b010, 1'b1);
        wake(w, n, r);
        check(32'(n), 32'd99, "timer wake in power-down");
        w = '0;
        w.ext_irq_lines_high = 4'h8;
        wake(w, n, r);
        check(32'(n < 40), 32'h1, "level line wake");
        enter(3'b010, 1'b1);
        w = '0;
        w.wdt_reset = 1'b1;
        wake(w, n, r);
        check(32'(r), 32'h1, "reset-type wake");
        bus(1'b1, smc_reg_power_control, 8'h00, rd);
        bus(1'b0, smc_reg_wake_status, 8'h00, rd);
        check(rd, 32'h1, "wake status set");
        bus(1'b1, smc_reg_wake_status, 8'h01, rd);
        bus(1'b0, smc_reg_wake_status, 8'h00, rd);
        check(rd, 32'h0, "wake status cleared");
    endtask

    task automatic t_noxtal;
        logic [31:0] rd;
        smc_wake_type w;
        int n;
        logic r;
        xtal <= 1'b0;
        adc_enabled <= 1'b0;
        enter(3'b110, 1'b1);
        check(32'(st), 32'h4f, "standby without crystal");
        bus(1'b0, smc_reg_clock_status, 8'h00, rd);
        check(rd, 32'h10f, "clock status asleep");
        w = '0;
        w.any_irq = 1'b1;
        wake(w, n, r);
        check(32'(n < 40), 32'h1, "idle wake");
    endtask

    initial begin
        nrst = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sleep_go = 1'b0;
        wake_go = '0;
        xtal = 1'b1;
        adc_enabled = 1'b1;
        timer_ctx = 3'b111;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_modes();
        t_timer();
        t_noxtal();
        final_report();
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
endmodule // smc_sleep_ctrl_tb
